// File: hw/cmph_cfg.svh
`ifndef CMPH_CFG_SVH
`define CMPH_CFG_SVH
// Clock rate in MHz, period 4 ns
`define CMPH_CLK_MHZ        250
// Cycles for a time in ns: least rounds up, longest rounds down
`define CMPH_NS_MIN(ns)     (((ns) * `CMPH_CLK_MHZ + 999) / 1000)
`define CMPH_NS_MAX(ns)     (((ns) * `CMPH_CLK_MHZ) / 1000)
// Printed times in ns
`define CMPH_T_SETUP_NS     40
`define CMPH_T_MQ_HOLD_NS   145
`define CMPH_T_MQ_DROP_NS   600
`define CMPH_T_DM_FULL_NS   310
`define CMPH_T_DM_LOW_NS    170
`define CMPH_T_DM_WIDTH_NS  80
`define CMPH_T_DM_BYTE_NS   475
`define CMPH_T_BYTE_MAX_NS  1300
`define CMPH_T_DATA_HOLD_NS 480
`define CMPH_T_START_MAX_NS 120
// Derived cycle counts
`define CMPH_C_SETUP        `CMPH_NS_MIN(`CMPH_T_SETUP_NS)
`define CMPH_C_MQ_HOLD      `CMPH_NS_MIN(`CMPH_T_MQ_HOLD_NS + `CMPH_T_START_MAX_NS)
`define CMPH_C_DM_MIN       `CMPH_NS_MIN(`CMPH_T_DM_WIDTH_NS)
`define CMPH_C_DATA_HOLD    `CMPH_NS_MIN(`CMPH_T_DATA_HOLD_NS + `CMPH_T_START_MAX_NS)
`define CMPH_C_DM_BYTE      `CMPH_NS_MIN(`CMPH_T_DM_BYTE_NS)
`define CMPH_C_TIMEOUT      `CMPH_NS_MAX(`CMPH_T_BYTE_MAX_NS)
// Byte lanes: left byte is bits 00-07 (MSBs), right byte 08-15 (LSBs)
`define CMPH_LEFT_HI        15
`define CMPH_LEFT_LO        8
`define CMPH_RIGHT_HI       7
`define CMPH_RIGHT_LO       0
`define CMPH_CNT_W          9
`endif

// File: hw/cmph_pkg.sv
package cmph_pkg;
  // Access kind from the two byte-write selects
  typedef enum logic [1:0] {
    CMPH_OP_READ  = 2'h0,
    CMPH_OP_RIGHT = 2'h1,
    CMPH_OP_LEFT  = 2'h2,
    CMPH_OP_FULL  = 2'h3
  } cmph_op_type;
  // User request
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        left_w;
    logic        right_w;
  } cmph_req_type;
  // User answer
  typedef struct packed {
    logic [15:0] rdata;
    logic        parity_err;
    logic        timeout;
  } cmph_rsp_type;
endpackage

// File: hw/cmph_sync2.sv
`timescale 1ns/1ps
// Two-flop synchroniser for pin inputs
module cmph_sync2 #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_r;  // First stage, read only by second
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_nxt;
  // Shift pins through two stages
  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end
  // Register both stages
  always_ff @(posedge core_clk) begin
    if (reset) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= meta_nxt;
      sync_out <= sync_nxt;
    end
  end
endmodule

// File: hw/cmph_host.sv
`timescale 1ns/1ps
`include "cmph_cfg.svh"
// Notes on behaviour
// - Address, selects stable 40 ns before request.
// - Request held 145 ns, dropped by 600.
// - Both selects low: read-restore, then done.
// - Partial write: merged parity, strobe within 1.3us.
// - Strobe held high only without byte writes.
// - Hold write data while write strobe high.
// - Full write strobe by 310, past 170, 80 wide.
// - Byte write strobe by 1300, not before 475.
// - Byte strobe after read strobe, post parity.
// - Left select bits 00-07, right 08-15.
// - Select encoding picks read, byte or full write.
// - Full write: strobe and data with request.
// - After cycle-started edge, next access may change.
module cmph_host
  import cmph_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic         req_valid,
  output logic              req_ready,
  input  wire cmph_req_type req,
  output logic              rsp_valid,
  output cmph_rsp_type      rsp,
  input  wire logic         bank_hit,
  input  wire logic         cycle_started_pulse,
  input  wire logic         read_data_strobe,
  output logic [15:0]       word_address_lines,
  output logic              left_byte_write,
  output logic              right_byte_write,
  output logic              memory_request,
  output logic              write_data_strobe,
  output logic              port_reset,
  input  wire logic [15:0]  word_data_lines_i,
  input  wire logic         parity_line_i,
  output logic [15:0]       word_data_lines_o,
  output logic              parity_line_o,
  output logic              data_oe,
  output logic              bank_hit_seen
);
  // Host state machine, one-hot
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_SETUP = 7'h02,
    ST_WAIT  = 7'h04,
    ST_HOLD  = 7'h08,
    ST_DATA  = 7'h10,
    ST_MERGE = 7'h20,
    ST_STRB  = 7'h40
  } cmph_st_type;

  // Odd parity: parity bit makes total count of ones odd
  function automatic logic odd_par(input logic [15:0] d);
    odd_par = ~(^d);
  endfunction

  // Synchronised pins
  logic [19:0] pins_s;
  logic        hit_s, rel_s, ds_s, par_s;
  logic [15:0] din_s;
  cmph_sync2 #(.W(20)) u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .async_in ({bank_hit, cycle_started_pulse, read_data_strobe,
                parity_line_i, word_data_lines_i}),
    .sync_out (pins_s)
  );
  assign {hit_s, rel_s, ds_s, par_s, din_s} = pins_s;

  cmph_st_type            st_r, st_nxt;        // Control state
  logic [`CMPH_CNT_W-1:0] cnt_r, cnt_nxt;      // Time since start of phase
  logic [`CMPH_CNT_W-1:0] dm_r, dm_nxt;        // Strobe high time
  logic [15:0]            addr_r, addr_nxt;    // Address drive
  logic [15:0]            wd_r, wd_nxt;        // Write data drive
  logic                   par_r, par_nxt;      // Parity drive
  logic                   lw_r, lw_nxt;        // Left select
  logic                   rw_r, rw_nxt;        // Right select
  logic                   mq_r, mq_nxt;        // Request pin
  logic                   dms_r, dms_nxt;      // Write data strobe pin
  logic                   oe_r, oe_nxt;        // Data bus drive enable
  logic                   rel_seen_r, rel_seen_nxt;
  logic                   done_r, done_nxt;    // Answer pulse
  cmph_rsp_type           rsp_r, rsp_nxt;      // Answer data
  logic                   hit_r, hit_nxt;      // Registered bank hit

  // Next-state logic for the whole transfer
  always_comb begin
    st_nxt       = st_r;
    cnt_nxt      = cnt_r + `CMPH_CNT_W'(1);
    dm_nxt       = dms_r ? dm_r + `CMPH_CNT_W'(1) : '0;
    addr_nxt     = addr_r;
    wd_nxt       = wd_r;
    par_nxt      = par_r;
    lw_nxt       = lw_r;
    rw_nxt       = rw_r;
    mq_nxt       = mq_r;
    dms_nxt      = dms_r;
    oe_nxt       = oe_r;
    rel_seen_nxt = rel_seen_r;
    done_nxt     = 1'b0;
    rsp_nxt      = rsp_r;
    hit_nxt      = hit_s;
    unique case (st_r)
      ST_IDLE: begin
        cnt_nxt = '0;
        if (req_valid) begin
          // Latch everything before the request rises
          addr_nxt = req.addr;
          lw_nxt   = req.left_w;
          rw_nxt   = req.right_w;
          wd_nxt   = req.wdata;
          par_nxt  = odd_par(req.wdata);
          oe_nxt   = req.left_w & req.right_w;
          rsp_nxt  = '0;
          st_nxt   = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (cnt_r >= `CMPH_NS_MIN(`CMPH_T_SETUP_NS)) begin
          mq_nxt       = 1'b1;
          dms_nxt      = lw_r & rw_r;
          cnt_nxt      = '0;
          rel_seen_nxt = 1'b0;
          st_nxt       = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // Hold request until memory confirms, plus minimum hold
        // Address and selects stay put until the start is confirmed
        if (rel_s) begin
          rel_seen_nxt = 1'b1;
        end
        if ((rel_s | rel_seen_r) && cnt_r >= `CMPH_C_MQ_HOLD) begin
          mq_nxt  = 1'b0;
          cnt_nxt = cnt_r + `CMPH_CNT_W'(1);
          st_nxt  = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (lw_r & rw_r) begin
          // Full write: hold data and strobe long enough
          if (cnt_r >= `CMPH_C_DATA_HOLD && dm_r >= `CMPH_C_DM_MIN) begin
            dms_nxt  = 1'b0;
            oe_nxt   = 1'b0;
            done_nxt = 1'b1;
            st_nxt   = ST_IDLE;
          end
        end else begin
          st_nxt = ST_DATA;
        end
      end
      ST_DATA: begin
        // Wait for memory data; timeout guards a dead bank
        if (ds_s) begin
          rsp_nxt.rdata      = din_s;
          rsp_nxt.parity_err = (odd_par(din_s) != par_s);
          if (!lw_r && !rw_r) begin
            done_nxt = 1'b1;
            st_nxt   = ST_IDLE;
          end else begin
            st_nxt = ST_MERGE;
          end
        end else if (cnt_r >= `CMPH_C_TIMEOUT) begin
          rsp_nxt.timeout = 1'b1;
          done_nxt        = 1'b1;
          st_nxt          = ST_IDLE;
        end
      end
      ST_MERGE: begin
        // Merge preserved byte with new byte after strobe ends
        if (!ds_s) begin
          if (lw_r) begin
            wd_nxt = {wd_r[`CMPH_LEFT_HI:`CMPH_LEFT_LO],
                      rsp_r.rdata[`CMPH_RIGHT_HI:`CMPH_RIGHT_LO]};
          end else begin
            wd_nxt = {rsp_r.rdata[`CMPH_LEFT_HI:`CMPH_LEFT_LO],
                      wd_r[`CMPH_RIGHT_HI:`CMPH_RIGHT_LO]};
          end
          st_nxt = ST_STRB;
        end
      end
      ST_STRB: begin
        // Parity formed one cycle after merge, then strobe
        par_nxt = odd_par(wd_r);
        oe_nxt  = 1'b1;
        if (oe_r) begin
          dms_nxt = 1'b1;
        end
        if (dms_r && dm_r >= `CMPH_C_DM_MIN && cnt_r >= `CMPH_C_DATA_HOLD) begin
          dms_nxt  = 1'b0;
          oe_nxt   = 1'b0;
          done_nxt = 1'b1;
          st_nxt   = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  // Register all state
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_r       <= ST_IDLE;
      cnt_r      <= '0;
      dm_r       <= '0;
      addr_r     <= '0;
      wd_r       <= '0;
      par_r      <= 1'b0;
      lw_r       <= 1'b0;
      rw_r       <= 1'b0;
      mq_r       <= 1'b0;
      dms_r      <= 1'b0;
      oe_r       <= 1'b0;
      rel_seen_r <= 1'b0;
      done_r     <= 1'b0;
      rsp_r      <= '0;
      hit_r      <= 1'b0;
    end else begin
      st_r       <= st_nxt;
      cnt_r      <= cnt_nxt;
      dm_r       <= dm_nxt;
      addr_r     <= addr_nxt;
      wd_r       <= wd_nxt;
      par_r      <= par_nxt;
      lw_r       <= lw_nxt;
      rw_r       <= rw_nxt;
      mq_r       <= mq_nxt;
      dms_r      <= dms_nxt;
      oe_r       <= oe_nxt;
      rel_seen_r <= rel_seen_nxt;
      done_r     <= done_nxt;
      rsp_r      <= rsp_nxt;
      hit_r      <= hit_nxt;
    end
  end

  // Pin and user outputs
  assign req_ready          = (st_r == ST_IDLE);
  assign rsp_valid          = done_r;
  assign rsp                = rsp_r;
  assign word_address_lines = addr_r;
  assign left_byte_write    = lw_r;
  assign right_byte_write   = rw_r;
  assign memory_request     = mq_r;
  assign write_data_strobe  = dms_r;
  assign port_reset         = reset;
  assign word_data_lines_o  = wd_r;
  assign parity_line_o      = par_r;
  assign data_oe            = oe_r;
  assign bank_hit_seen      = hit_r;
endmodule

// File: tb/cmph_host_assertions.sv
`timescale 1ns/1ps
// Pin protocol checks, host side only
module cmph_host_assertions
  import cmph_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        bank_hit,
  input wire logic        cycle_started_pulse,
  input wire logic        read_data_strobe,
  input wire logic [15:0] word_address_lines,
  input wire logic        left_byte_write,
  input wire logic        right_byte_write,
  input wire logic        memory_request,
  input wire logic        write_data_strobe,
  input wire logic        port_reset,
  input wire logic [15:0] word_data_lines_o,
  input wire logic        parity_line_o,
  input wire logic        data_oe,
  input wire logic        bank_hit_seen
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  logic [9:0] since_r;  // Cycles since request rose
  logic [5:0] dm_cnt_r; // Strobe high run length
  logic       ds_seen_r; // Read strobe seen since request rose
  wire        byte_w = left_byte_write ^ right_byte_write;
  // Counters saturate so long stalls never wrap
  always_ff @(posedge core_clk) begin
    if (reset || $rose(memory_request)) since_r <= 10'h0;
    else if (since_r != 10'h3FF) since_r <= since_r + 10'h1;
    dm_cnt_r <= !write_data_strobe ? 6'h0 : dm_cnt_r + {5'h0, dm_cnt_r != 6'h3F};
    if (reset || $rose(memory_request)) ds_seen_r <= 1'b0;
    else if (read_data_strobe) ds_seen_r <= 1'b1;
  end
  a_addr_setup: assert property ($rose(memory_request) |-> $past({word_address_lines,
    left_byte_write, right_byte_write}, 9) == {word_address_lines, left_byte_write,
    right_byte_write}) else $error("address not set up before request");
  a_addr_hold: assert property (memory_request && $past(memory_request) |->
    $stable({word_address_lines, left_byte_write, right_byte_write}))
    else $error("address moved under request");
  a_full_start: assert property ($rose(memory_request) |->
    write_data_strobe == (left_byte_write && right_byte_write) && data_oe == write_data_strobe)
    else $error("write strobe wrong at request");
  a_req_hold: assert property ($fell(memory_request) |-> since_r >= 10'h42)
    else $error("request dropped early");
  a_req_drop: assert property ($rose(cycle_started_pulse) |-> ##[1:140] !memory_request)
    else $error("request held too long");
  a_dm_width: assert property ($fell(write_data_strobe) |-> dm_cnt_r >= 6'h14)
    else $error("write strobe too narrow");
  a_full_dm_late: assert property ($fell(write_data_strobe) && left_byte_write &&
    right_byte_write |-> since_r >= 10'h48) else $error("full write strobe dropped early");
  a_byte_dm_late: assert property ($fell(write_data_strobe) && byte_w |->
    since_r >= 10'h94) else $error("byte write strobe dropped early");
  a_byte_dm_order: assert property ($rose(write_data_strobe) && byte_w |->
    ds_seen_r && since_r <= 10'h155) else $error("byte write strobe misplaced");
  a_par_odd: assert property (data_oe |-> ^{parity_line_o, word_data_lines_o})
    else $error("even parity driven");
  a_data_hold: assert property (write_data_strobe && $past(write_data_strobe) |->
    data_oe && $stable({parity_line_o, word_data_lines_o})) else $error("data moved");
  a_reset_pass: assert property (disable iff (1'b0) port_reset == reset)
    else $error("reset pin differs");
  a_bank_seen: assert property (bank_hit_seen == $past(bank_hit, 3))
    else $error("bank hit flag lags");
endmodule
bind cmph_host cmph_host_assertions chk (.*);

// File: tb/cmph_mem_model.sv
`timescale 1ns/1ps
// Behavioural core memory bank, one port, 16 words
module cmph_mem_model #(
  parameter logic [1:0] BANK = 2'h2
) (
  input wire logic        core_clk,
  input wire logic        port_reset,
  input wire logic [15:0] word_address_lines,
  input wire logic        left_byte_write,
  input wire logic        right_byte_write,
  input wire logic        memory_request,
  input wire logic        write_data_strobe,
  input wire logic [15:0] word_data_lines_o,
  input wire logic        parity_line_o,
  input wire logic        data_oe,
  input wire logic [4:0]  start_dly,
  input wire logic        bad_par,
  output logic            bank_hit,
  output logic            cycle_started_pulse,
  output logic            read_data_strobe,
  output logic [16:0]     bus
);
  logic [16:0] mem [16];
  logic [16:0] last_r, dreg_r;
  logic        wrote_r, dm_q;
  int          c, t;     // c counts from request, t from cycle start
  wire [3:0]   ix = word_address_lines[3:0];
  wire         full = left_byte_write && right_byte_write;
  wire         rd = !left_byte_write && !right_byte_write;
  // Pins derived from the cycle position
  always_comb begin
    t = c - int'(start_dly);
    bank_hit = word_address_lines[15:14] == BANK;
    cycle_started_pulse = t >= 5 && t < 25;
    read_data_strobe = !full && t >= 90 && t < 110;
    bus = ~last_r; // Released bus toggles so no stale value reads as good
    if (data_oe) bus = {parity_line_o, word_data_lines_o};
    else if (!full && t >= 75 && t < 140) begin
      bus = mem[ix] ^ {bad_par, 16'h0};
      if (left_byte_write) bus[15:8] = ~bus[15:8]; // Written lane unreadable
      if (right_byte_write) bus[7:0] = ~bus[7:0];
    end
  end
  // Cycle sequencing and storage
  always_ff @(posedge core_clk) begin
    last_r <= bus;
    dm_q <= write_data_strobe;
    if (write_data_strobe) dreg_r <= bus;
    if (port_reset) begin
      c <= -1;
      wrote_r <= 1'b0;
    end else if (c < 0) c <= memory_request ? 0 : -1; // lone port, always served next
    else begin
      c <= c + 1;
      if (dm_q && !write_data_strobe && !rd) begin
        mem[ix] <= {dreg_r[16], left_byte_write ? dreg_r[15:8] : mem[ix][15:8],
          right_byte_write ? dreg_r[7:0] : mem[ix][7:0]};
        wrote_r <= 1'b1;
      end
      if (t > 400 || (t >= 140 && !memory_request && !write_data_strobe && (rd || wrote_r)))
      begin
        c <= -1;
        wrote_r <= 1'b0;
      end else if (t == 150 && memory_request) begin
        c <= 0;
        wrote_r <= 1'b0;
      end
    end
  end
endmodule

// File: tb/cmph_host_tb.sv
`timescale 1ns/1ps
module cmph_host_tb;
  import cmph_pkg::*;
  logic core_clk, reset, req_valid, req_ready, rsp_valid, bank_hit, cycle_started_pulse;
  logic read_data_strobe, left_byte_write, right_byte_write, memory_request, write_data_strobe;
  logic port_reset, parity_line_i, parity_line_o, data_oe, bank_hit_seen, bad_par;
  logic [15:0] word_address_lines, word_data_lines_i, word_data_lines_o, d;
  logic [16:0] bus;
  logic [4:0]  start_dly;
  logic [3:0]  ix;
  logic [1:0]  op;
  logic [15:0] shadow [16]; // Expected memory contents
  cmph_req_type req;
  cmph_rsp_type rsp;
  int failures, samples_checked;
  assign {parity_line_i, word_data_lines_i} = bus;
  cmph_host uut (.*);
  cmph_mem_model #(.BANK(2'h2)) mem (.*);
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic give_verdict();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (!ok) begin
      failures++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  // One access, slow or prompt memory at random
  task automatic access(input logic l, input logic r, input logic [3:0] a, input logic [15:0] w);
    int n;
    @(posedge core_clk);
    req <= '{addr: {2'h2, 10'h0, a}, wdata: w, left_w: l, right_w: r};
    start_dly <= 5'(17 + $urandom % 14);
    req_valid <= 1'b1;
    n = 0;
    do @(negedge core_clk); while (!req_ready && ++n < 50);
    if (n >= 50) chk(1'b0, "never ready");
    @(posedge core_clk);
    req_valid <= 1'b0;
    n = 0;
    do @(negedge core_clk); while (rsp_valid !== 1'b1 && ++n < 2000);
    if (n >= 2000) begin
      chk(1'b0, "no answer");
      give_verdict();
    end
  endtask
  // Byte lane merge: left select owns the upper byte
  function automatic logic [15:0] merge(logic [15:0] o, logic [15:0] w, logic l, logic r);
    return {l ? w[15:8] : o[15:8], r ? w[7:0] : o[7:0]};
  endfunction
  initial begin
    reset = 1'b1;
    req_valid = 1'b0;
    req = '0;
    start_dly = 5'h14;
    bad_par = 1'b0;
    void'($urandom(97));
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      shadow[i] = 16'($urandom);
      access(1'b1, 1'b1, 4'(i), shadow[i]);
      chk(rsp.timeout === 1'b0, "full write");
    end
    repeat (40) begin
      op = 2'($urandom);
      ix = 4'($urandom);
      d = 16'($urandom);
      access(op[1], op[0], ix, d);
      if (op == 2'h0) chk(rsp.rdata === shadow[ix] && rsp.parity_err === 1'b0, "read");
      else begin
        shadow[ix] = merge(shadow[ix], d, op[1], op[0]);
        chk(rsp.timeout === 1'b0, "write");
      end
    end
    // Mid-run reset: long enough that the bank hit history is flushed
    reset <= 1'b1;
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    @(negedge core_clk);
    chk(memory_request === 1'b0 && req_ready === 1'b1 && rsp_valid === 1'b0, "reset");
    // Back to back byte writes to one word, then read back
    access(1'b1, 1'b0, 4'h5, 16'hA5C3);
    access(1'b0, 1'b1, 4'h5, 16'h3C5A);
    access(1'b0, 1'b0, 4'h5, 16'h0);
    chk(rsp.rdata === 16'hA55A && rsp.parity_err === 1'b0, "merge");
    @(posedge core_clk);
    bad_par <= 1'b1;
    access(1'b0, 1'b0, 4'h5, 16'h0);
    chk(rsp.parity_err === 1'b1, "parity");
    chk(bank_hit_seen === 1'b1, "bank hit");
    give_verdict();
  end
endmodule
